// >>> src/pointing_pkg.sv
package pointing_pkg;
    localparam int CHAN_W            = 16;
    localparam int POS_W             = 32;
    localparam int CLK_HZ            = 20_000_000;
    localparam int CYC_PER_US        = CLK_HZ / 1_000_000;
    localparam int DELAY_CNT_W       = 24;
    localparam logic [15:0] FIRST_DELAY_US_RESET  = 16'h0064;
    localparam logic [15:0] SECOND_DELAY_US_RESET = 16'h0064;
    localparam logic [15:0] DIFF_RATE_LIMIT_HZ    = 16'h0FA0;
    localparam int NORM_SCALE        = 10000;
    localparam logic signed [15:0] SUM_TARGET     = 16'sh1388;
    localparam logic signed [15:0] AUTOGAIN_TOL   = 16'sh0064;
    localparam logic [15:0] GAIN_MIN              = 16'h000A;
    localparam logic [15:0] GAIN_MAX              = 16'h03E8;
    localparam logic [15:0] GAIN_RESET            = 16'h0064;
    localparam logic [15:0] GAIN_STEP             = 16'h0001;
    localparam int LOOP_SHIFT        = 4;
    localparam int STEPS_PER_MRAD    = 1000;
    localparam int CH_SUM_A          = 4;
    localparam int CH_SUM_B          = 5;

    typedef enum {SMP_IDLE, SMP_WAIT1, SMP_WAIT2} smp_state_t;
endpackage : pointing_pkg

// >>> src/sample_if.sv
interface sample_if;
    logic [5:0][15:0] liveData;
    logic             liveValid;
    logic             trigger;
    logic             pulsed;
    logic             differential;
    logic [23:0]      delay1Cyc;
    logic [23:0]      delay2Cyc;
    logic [5:0][15:0] outData;
    logic             outValid;
    logic             busy;

    modport ctrl (output liveData, liveValid, trigger, pulsed, differential, delay1Cyc,
                  delay2Cyc, input outData, outValid, busy);
    modport smp  (input liveData, liveValid, trigger, pulsed, differential, delay1Cyc,
                  delay2Cyc, output outData, outValid, busy);
endinterface : sample_if

// >>> src/pulse_sampler.sv
module pulse_sampler (
    input  wire logic ref_clk,   // System clock
    input  wire logic reset_n,   // Async reset
    sample_if.smp     sif        // Sample path
);
    pointing_pkg::smp_state_t stateQ;
    logic [23:0]      cntQ;
    logic [5:0][15:0] peakQ;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stateQ       <= pointing_pkg::SMP_IDLE;
            cntQ         <= '0;
            peakQ        <= '0;
            sif.outData  <= '0;
            sif.outValid <= 1'b0;
        end else begin
            sif.outValid <= 1'b0;
            unique case (stateQ)
                pointing_pkg::SMP_IDLE: begin
                    if (!sif.pulsed) begin
                        sif.outValid <= sif.liveValid;
                        if (sif.liveValid) sif.outData <= sif.liveData;
                    end else if (sif.trigger) begin // RL9
                        stateQ <= pointing_pkg::SMP_WAIT1;
                        cntQ   <= sif.delay1Cyc;  // RL12
                    end
                end
                pointing_pkg::SMP_WAIT1: begin
                    if (cntQ <= 24'h000001) begin
                        if (sif.differential) begin
                            peakQ  <= sif.liveData; // RL12
                            cntQ   <= sif.delay2Cyc;
                            stateQ <= pointing_pkg::SMP_WAIT2;
                        end else begin
                            sif.outData  <= sif.liveData; // RL13
                            sif.outValid <= 1'b1;         // RL7
                            stateQ       <= pointing_pkg::SMP_IDLE;
                        end
                    end else begin
                        cntQ <= cntQ - 24'h000001;
                    end
                end
                pointing_pkg::SMP_WAIT2: begin
                    if (cntQ <= 24'h000001) begin
                        for (int i = 0; i < 6; i++) begin
                            sif.outData[i] <= peakQ[i] - sif.liveData[i]; // RL11
                        end
                        sif.outValid <= 1'b1;
                        stateQ       <= pointing_pkg::SMP_IDLE;
                    end else begin
                        cntQ <= cntQ - 24'h000001;
                    end
                end
            endcase
        end
    end

    assign sif.busy = (stateQ != pointing_pkg::SMP_IDLE);

    // Pulses arriving mid-sample are dropped: one update per accepted pulse
    a_one_per_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (sif.pulsed && sif.outValid) |=> !sif.outValid) else $error("double update"); // RL7
    a_idle_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (sif.pulsed && stateQ == pointing_pkg::SMP_IDLE && !sif.trigger)
        |=> !sif.outValid) else $error("update without pulse"); // RL8
    // Delays are whole microseconds, so watch the tail of the count instead
    a_single_delay: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (stateQ == pointing_pkg::SMP_WAIT1 && cntQ == 24'h000003 && !sif.differential)
        |=> !sif.outValid [*2] ##1 sif.outValid) else $error("single sample timing"); // RL13
endmodule : pulse_sampler

// >>> src/pointing_regulator_supervisor.sv
// Functional notes
// [RL1] Normalise pointing by own chip intensity sum
// [RL2] Stop regulator when intensity outside limits
// [RL3] Motor idle while all values inside deadband
// [RL4] Zero deadband means continuous regulation
// [RL5] Switch-off inside good threshold: hold actuators
// [RL6] Switch-off outside good threshold: revert actuators
// [RL7] Each pulse gives exactly one regulator update
// [RL8] Regulator idle until next pulse arrives
// [RL9] Pulsed select routes through sample-and-hold
// [RL10] Internal trigger from detector, else external
// [RL11] Below 4 kHz: peak minus idle sample
// [RL12] Differential: delay1, peak, delay2, idle sample
// [RL13] Above 4 kHz: one sample after delay1
// [RL14] First delay defaults to 100 us, adjustable
// [RL15] Operator keeps preamplifier gains 10 to 1000
// [RL16] Autogain drives both sums toward 5 V
// [RL17] Detector offsets shift the regulation setpoint
// [RL18] One motor offset unit is one mrad
// [RL19] Operator picks single sampling for bursts
// [RL20] Enable is one bit; checks on falling edge
// [RL21] Rate selects sampling; delays are cycle counters
// [RL22] Store actuator positions at each enable
module pointing_regulator_supervisor #(
    parameter int STEPS_PER_MRAD = pointing_pkg::STEPS_PER_MRAD
) (
    input  wire logic                     ref_clk,               // 20 MHz clock
    input  wire logic                     reset_n,               // Async reset
    input  wire logic [5:0][15:0]         adcData,               // Ax,Ay,Bx,By,SumA,SumB
    input  wire logic                     adcValid,              // Conversion strobe
    input  wire logic                     extTriggerPin,         // External pulse trigger
    input  wire logic                     useExtTrigger,         // Select external trigger
    input  wire logic signed [15:0]       triggerLevel,          // Internal trigger level
    input  wire logic                     continuousOrPulsedSelect, // 1 = pulsed
    input  wire logic                     singleSelect,          // Force single sampling
    input  wire logic [15:0]              repRateHz,             // Configured rep rate
    input  wire logic [15:0]              firstSampleDelay,      // Delay 1 in us
    input  wire logic [15:0]              secondSampleDelay,     // Delay 2 in us
    input  wire logic                     delayLoad,             // Load both delays
    input  wire logic signed [15:0]       intensityLowLimit,     // Min intensity
    input  wire logic signed [15:0]       intensityHighLimit,    // Max intensity
    input  wire logic [15:0]              motorDeadband,         // Motor inactive band
    input  wire logic [15:0]              positionGoodThreshold, // Switch-off check band
    input  wire logic                     regulatorEnableFlag,   // 1 = regulator on
    input  wire logic signed [3:0][15:0]  detectorOffset,        // Setpoint shifts
    input  wire logic signed [3:0][15:0]  motorOffset,           // Offsets in mrad
    input  wire logic                     autoGainStart,         // Start autogain
    output logic signed [3:0][15:0]       normPointing,          // Normalised pointing
    output logic signed [3:0][31:0]       actuatorPos,           // Actuator targets
    output logic [15:0]                   gainA,                 // Chip A preamp gain
    output logic [15:0]                   gainB,                 // Chip B preamp gain
    output logic                          regulatorRunning,      // Enabled and intensity ok
    output logic                          intensityOkFlag,       // Sums inside limits
    output logic                          positionOkFlag,        // Pointing inside good band
    output logic                          autoGainBusy,          // Autogain in progress
    output logic                          updatePulse            // One regulator update
);
    sample_if sif ();

    logic             trigSync1Q, trigSync2Q, trigSync3Q;
    logic             sumAbovePrevQ;
    logic [15:0]      delay1Q, delay2Q;
    logic             normValidQ;
    logic             regEnQ, regEnPrevQ;
    logic             movedQ;
    logic signed [3:0][31:0] posQ, savedPosQ;
    logic signed [3:0][16:0] err;
    logic             rise, fall, stepGo, sumOk;

    // Saturating scaled division; zero sum gives zero
    function automatic logic signed [15:0] normalize(input logic signed [15:0] v,
                                                     input logic signed [15:0] s);
        logic signed [47:0] q;
        q = 48'sd0;
        if (s > 16'sd0) q = (48'(v) * 48'(pointing_pkg::NORM_SCALE)) / 48'(s);
        if (q > 48'sd32767) q = 48'sd32767;
        if (q < -48'sd32767) q = -48'sd32767;
        return q[15:0];
    endfunction : normalize

    function automatic logic any_outside(input logic signed [3:0][16:0] e,
                                         input logic [15:0] th);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (($signed(e[i]) < 0 ? -$signed(e[i]) : $signed(e[i])) > $signed({1'b0, th}))
                r = 1'b1;
        end
        return r;
    endfunction : any_outside

    function automatic logic sums_in_range(input logic [5:0][15:0] d,
                                           input logic signed [15:0] lo,
                                           input logic signed [15:0] hi);
        return $signed(d[pointing_pkg::CH_SUM_A]) >= lo && $signed(d[pointing_pkg::CH_SUM_A]) <= hi
            && $signed(d[pointing_pkg::CH_SUM_B]) >= lo && $signed(d[pointing_pkg::CH_SUM_B]) <= hi;
    endfunction : sums_in_range

    // Trigger pin synchroniser; edge detect reads stages two and three only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trigSync1Q <= 1'b0;
            trigSync2Q <= 1'b0;
            trigSync3Q <= 1'b0;
        end else begin
            trigSync1Q <= extTriggerPin;
            trigSync2Q <= trigSync1Q;
            trigSync3Q <= trigSync2Q;
        end
    end

    // Internal trigger: intensity sum crossing upward through the level
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sumAbovePrevQ <= 1'b0;
        end else if (adcValid) begin
            sumAbovePrevQ <= $signed(adcData[pointing_pkg::CH_SUM_A]) > triggerLevel;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            delay1Q <= pointing_pkg::FIRST_DELAY_US_RESET;  // RL14
            delay2Q <= pointing_pkg::SECOND_DELAY_US_RESET;
        end else if (delayLoad) begin
            delay1Q <= firstSampleDelay;                    // RL14
            delay2Q <= secondSampleDelay;
        end
    end

    assign sif.liveData  = adcData;
    assign sif.liveValid = adcValid;
    assign sif.pulsed    = continuousOrPulsedSelect;                              // RL9
    assign sif.trigger   = useExtTrigger ? (trigSync2Q && !trigSync3Q)            // RL10
                         : (adcValid && !sumAbovePrevQ
                            && $signed(adcData[pointing_pkg::CH_SUM_A]) > triggerLevel);
    // Bursts are handled by the operator forcing single sampling
    assign sif.differential = (repRateHz < pointing_pkg::DIFF_RATE_LIMIT_HZ)      // RL21
                            && !singleSelect;                                     // RL19
    localparam int DELAY_CNT_W = pointing_pkg::DELAY_CNT_W;

    // Zero delay still takes one cycle
    assign sif.delay1Cyc = DELAY_CNT_W'(delay1Q) * 24'(pointing_pkg::CYC_PER_US); // RL21
    assign sif.delay2Cyc = DELAY_CNT_W'(delay2Q) * 24'(pointing_pkg::CYC_PER_US);

    pulse_sampler pulse_sampler_inst (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .sif     (sif.smp)
    );

    // Normalisation stage, one result per sampler output
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            normPointing    <= '0;
            normValidQ      <= 1'b0;
            intensityOkFlag <= 1'b0;
        end else begin
            normValidQ <= sif.outValid;
            if (sif.outValid) begin
                for (int i = 0; i < 4; i++) begin
                    normPointing[i] <= normalize($signed(sif.outData[i]),               // RL1
                                                 $signed(sif.outData[i < 2 ? pointing_pkg::CH_SUM_A
                                                                           : pointing_pkg::CH_SUM_B]));
                end
                intensityOkFlag <= sums_in_range(sif.outData, intensityLowLimit,
                                                 intensityHighLimit);                  // RL2
            end
        end
    end

    // Offsets move the setpoint rather than being fought by the loop
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            // Packed elements are unsigned: sign must be restored before widening
            err[i] = 17'($signed(normPointing[i])) - 17'($signed(detectorOffset[i])); // RL17
        end
    end

    assign rise   = regEnQ && !regEnPrevQ;
    assign fall   = !regEnQ && regEnPrevQ;                                              // RL20
    assign sumOk  = intensityOkFlag;
    assign stepGo = normValidQ && regEnQ && regEnPrevQ && sumOk                         // RL2
                 && (motorDeadband == 16'h0000                                          // RL4
                     || any_outside(err, motorDeadband));                               // RL3

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            regEnQ     <= 1'b0;
            regEnPrevQ <= 1'b0;
        end else begin
            regEnQ     <= regulatorEnableFlag;
            regEnPrevQ <= regEnQ;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            savedPosQ <= '0;
        end else if (rise) begin
            savedPosQ <= posQ;                                                          // RL22
        end
    end

    // Loop runs only on fresh samples, so pulsed mode idles between pulses
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            posQ   <= '0;
            movedQ <= 1'b0;
        end else begin
            movedQ <= stepGo;
            if (fall) begin
                if (any_outside(err, positionGoodThreshold)) begin
                    posQ <= savedPosQ;                                                  // RL6
                end
            end else if (stepGo) begin                                                  // RL8
                for (int i = 0; i < 4; i++) begin
                    posQ[i] <= posQ[i]
                        - 32'($signed(err[i]) >>> pointing_pkg::LOOP_SHIFT);            // RL7
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            actuatorPos      <= '0;
            regulatorRunning <= 1'b0;
            positionOkFlag   <= 1'b0;
            updatePulse      <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                actuatorPos[i] <= posQ[i]
                    + 32'($signed(motorOffset[i])) * 32'(STEPS_PER_MRAD);               // RL18
            end
            regulatorRunning <= regEnQ && sumOk;
            positionOkFlag   <= !any_outside(err, positionGoodThreshold);
            updatePulse      <= stepGo;
        end
    end

    // Autogain: one gain step per sample until both sums sit in the window
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gainA        <= pointing_pkg::GAIN_RESET;
            gainB        <= pointing_pkg::GAIN_RESET;
            autoGainBusy <= 1'b0;
        end else if (autoGainStart) begin
            autoGainBusy <= 1'b1;
        end else if (autoGainBusy && sif.outValid) begin
            if (gain_step_dir(sif.outData[pointing_pkg::CH_SUM_A]) > 0 && gainA < pointing_pkg::GAIN_MAX)
                gainA <= gainA + pointing_pkg::GAIN_STEP;                               // RL16
            else if (gain_step_dir(sif.outData[pointing_pkg::CH_SUM_A]) < 0 && gainA > pointing_pkg::GAIN_MIN)
                gainA <= gainA - pointing_pkg::GAIN_STEP;
            if (gain_step_dir(sif.outData[pointing_pkg::CH_SUM_B]) > 0 && gainB < pointing_pkg::GAIN_MAX)
                gainB <= gainB + pointing_pkg::GAIN_STEP;                               // RL16
            else if (gain_step_dir(sif.outData[pointing_pkg::CH_SUM_B]) < 0 && gainB > pointing_pkg::GAIN_MIN)
                gainB <= gainB - pointing_pkg::GAIN_STEP;
            if (gain_step_dir(sif.outData[pointing_pkg::CH_SUM_A]) == 0
                && gain_step_dir(sif.outData[pointing_pkg::CH_SUM_B]) == 0)
                autoGainBusy <= 1'b0;
        end
    end

    function automatic int gain_step_dir(input logic [15:0] s);
        if ($signed(s) < pointing_pkg::SUM_TARGET - pointing_pkg::AUTOGAIN_TOL) return 1;
        if ($signed(s) > pointing_pkg::SUM_TARGET + pointing_pkg::AUTOGAIN_TOL) return -1;
        return 0;
    endfunction : gain_step_dir

    a_norm_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sif.outValid |=> normValidQ) else $error("normalised value missing"); // RL1
    a_intensity_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (sif.outValid && !sums_in_range(sif.outData, intensityLowLimit, intensityHighLimit))
        |-> ##2 !movedQ) else $error("moved with bad intensity"); // RL2
    a_deadband_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (normValidQ && motorDeadband != 16'h0000 && !any_outside(err, motorDeadband))
        |=> !movedQ) else $error("moved inside deadband"); // RL3
    a_zero_deadband: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (normValidQ && regEnQ && regEnPrevQ && intensityOkFlag && motorDeadband == 16'h0000)
        |=> movedQ && updatePulse) else $error("no continuous update"); // RL4
    a_off_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fall && !any_outside(err, positionGoodThreshold)) |=> $stable(posQ))
        else $error("actuators moved on good switch-off"); // RL5
    a_off_revert: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fall && any_outside(err, positionGoodThreshold)) |=> posQ == $past(savedPosQ))
        else $error("actuators not reverted"); // RL6
    a_gain_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (autoGainBusy && sif.outValid) |=> gainA >= pointing_pkg::GAIN_MIN
        && gainA <= pointing_pkg::GAIN_MAX && gainB >= pointing_pkg::GAIN_MIN)
        else $error("gain out of range"); // RL16
    a_enable_capture: assert property (@(posedge ref_clk) disable iff (!reset_n)
        rise |=> savedPosQ == $past(posQ)) else $error("start position not stored"); // RL22
endmodule : pointing_regulator_supervisor

// >>> sim/detector_model.sv
module detector_model (
    input  wire logic             ref_clk,  // System clock
    input  wire logic             reset_n,  // Async reset
    input  wire logic [5:0][15:0] level,    // Beam readings to present
    output logic      [5:0][15:0] adcData,  // Converted readings
    output logic                  adcValid  // Conversion strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] divQ;
    // Conversion every 8 cycles; data held between strobes like a real converter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            divQ     <= 3'h0;
            adcValid <= 1'b0;
            adcData  <= '0;
        end else begin
            divQ     <= divQ + 3'h1;
            adcValid <= (divQ == 3'h7);
            if (divQ == 3'h7) begin
                adcData <= level;
            end
        end
    end
endmodule : detector_model

// >>> sim/pointing_regulator_supervisor_test.sv
module pointing_regulator_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, reset_n = 1'b0, adcValid, extTriggerPin = 1'b0, pulsed = 1'b0;
    logic enable = 1'b0, delayLoad = 1'b0, autoGainStart = 1'b0, updatePulse, singleSel = 1'b0;
    logic [5:0][15:0] level = '0, adcData;
    logic [15:0] repRate = 16'h1388, delay1 = 16'h0064, deadband = 16'h0000;
    logic [15:0] goodTh = 16'h000A, gainA, gainB;
    logic signed [3:0][15:0] detOff = '0, normPointing, motOff = '0;
    logic signed [3:0][31:0] actuatorPos;
    logic running, intOk, position_good_threshold, agBusy;
    int mismatches = 0, checked = 0, cycles = 0, updCount = 0, base;
    logic [31:0] held;
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (updatePulse === 1'b1) updCount <= updCount + 1;
        if (cycles > 20000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end
    detector_model detector_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .level(level),
        .adcData(adcData), .adcValid(adcValid));
    pointing_regulator_supervisor pointing_regulator_supervisor_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .adcData(adcData), .adcValid(adcValid),
        .extTriggerPin(extTriggerPin), .useExtTrigger(1'b1), .triggerLevel(16'sh0100),
        .continuousOrPulsedSelect(pulsed), .singleSelect(singleSel), .repRateHz(repRate),
        .firstSampleDelay(delay1), .secondSampleDelay(16'h0001), .delayLoad(delayLoad),
        .intensityLowLimit(16'sh0064), .intensityHighLimit(16'sh2710),
        .motorDeadband(deadband), .positionGoodThreshold(goodTh),
        .regulatorEnableFlag(enable), .detectorOffset(detOff), .motorOffset(motOff),
        .autoGainStart(autoGainStart), .normPointing(normPointing), .actuatorPos(actuatorPos),
        .gainA(gainA), .gainB(gainB), .regulatorRunning(running), .intensityOkFlag(intOk),
        .positionOkFlag(position_good_threshold), .autoGainBusy(agBusy), .updatePulse(updatePulse));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : wait_cyc
    task automatic do_reset();
        @(posedge ref_clk) reset_n <= 1'b0;
        enable <= 1'b0;
        wait_cyc(4);
        @(posedge ref_clk) reset_n <= 1'b1;
        level <= {16'h09C4, 16'h1388, 16'h0000, 16'h01F4, 16'hFE0C, 16'h03E8};
        wait_cyc(1);
        check(gainA, 32'h0000_0064);
        check(actuatorPos[0], 32'h0000_0000);
    endtask : do_reset
    task automatic test_norm();
        wait_cyc(12);
        check(normPointing[0], 32'h0000_07D0);
        check(normPointing[1], 32'h0000_FC18);
        check(normPointing[2], 32'h0000_07D0);
        check(intOk, 32'h1);
        @(posedge ref_clk) motOff[0] <= 16'shFFFF;
        wait_cyc(2);
        check(actuatorPos[0], 32'hFFFF_FC18);
        @(posedge ref_clk) motOff[0] <= 16'sh0000;
        $display("norm test done");
    endtask : test_norm
    task automatic test_deadband();
        @(posedge ref_clk) detOff <= {16'sh0000, 16'sh07D0, 16'shFC18, 16'sh07D0};
        deadband <= 16'h000A;
        enable <= 1'b1;
        wait_cyc(10);
        base = updCount;
        wait_cyc(40);
        check(updCount - base, 32'h0);
        @(posedge ref_clk) deadband <= 16'h0000;
        base = updCount;
        wait_cyc(40);
        check(updCount - base > 0, 32'h1);
        @(posedge ref_clk) level[4] <= 16'h2711;
        wait_cyc(12);
        base = updCount;
        wait_cyc(30);
        check({intOk, running}, 32'h0);
        check(updCount - base, 32'h0);
        @(posedge ref_clk) level[4] <= 16'h1388;
        enable <= 1'b0;
        detOff <= '0;
        $display("deadband test done");
    endtask : test_deadband
    task automatic test_switch_off(input logic [15:0] th);
        do_reset();
        @(posedge ref_clk) enable <= 1'b1;
        goodTh <= th;
        wait_cyc(60);
        held = actuatorPos[0];
        check(held != 0, 32'h1);
        @(posedge ref_clk) enable <= 1'b0;
        wait_cyc(6);
        // Small band: pointing is off, so revert to the enable-time position
        check(actuatorPos[0], (th == 16'h000A) ? 32'h0 : held);
        check(position_good_threshold, th != 16'h000A);
        $display("switch-off test done");
    endtask : test_switch_off
    task automatic test_pulse(input logic [15:0] rate, input logic single);
        do_reset();
        @(posedge ref_clk) pulsed <= 1'b1;
        repRate <= rate;
        singleSel <= single;
        delay1 <= 16'h0001;
        delayLoad <= 1'b1;
        enable <= 1'b1;
        @(posedge ref_clk) delayLoad <= 1'b0;
        wait_cyc(20);
        base = updCount;
        // External trigger stands in for a pulse arriving on the lit detector
        @(posedge ref_clk) extTriggerPin <= 1'b1;
        wait_cyc(2);
        @(posedge ref_clk) extTriggerPin <= 1'b0;
        wait_cyc(14);
        // Light gone by the idle sample: sums drop, pointing offsets stay
        @(posedge ref_clk) level[5:4] <= '0;
        wait_cyc(60);
        check(updCount - base, 32'h1);
        if (rate == 16'h03E8) check(normPointing[0], single ? 32'h07D0 : 32'h0);
        wait_cyc(100);
        check(updCount - base, 32'h1);
        @(posedge ref_clk) pulsed <= 1'b0;
        singleSel <= 1'b0;
        level[5:4] <= {16'h09C4, 16'h1388};
        $display("pulse test done");
    endtask : test_pulse
    task automatic test_gain();
        @(posedge ref_clk) autoGainStart <= 1'b1;
        @(posedge ref_clk) autoGainStart <= 1'b0;
        wait_cyc(40);
        check(agBusy, 32'h1);
        check(gainA, 32'h0000_0064);
        check(gainB > 16'h0064, 32'h1);
        @(posedge ref_clk) level[5] <= 16'h1388;
        wait_cyc(20);
        check(agBusy, 32'h0);
        $display("gain test done");
    endtask : test_gain
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        do_reset();
        test_norm();
        test_deadband();
        test_switch_off(16'h000A);
        test_switch_off(16'h7FFF);
        test_pulse(16'h1388, 1'b0);
        test_pulse(16'h03E8, 1'b0);
        test_pulse(16'h03E8, 1'b1);
        test_gain();
        stop_test();
    end
endmodule : pointing_regulator_supervisor_test
